// ---- rtl/scirq_params.svh ----
// Register offsets, field positions, reset values and widths of the
// system-control interrupt status and reset-cause block.
// Assumes a 32-bit AXI4-Lite register bus and byte addressing.
//
// What this block does
// [RQ1] Masked flag equals raw flag AND mask.
// [RQ2] Write one clears masked and raw flag.
// [RQ3] Bit 6: PLL ready timer expiry, masked.
// [RQ4] Bit 5: regulator current-limit event, masked.
// [RQ5] Bit 4: internal oscillator fault, masked.
// [RQ6] Bit 3: main oscillator fault, masked.
// [RQ7] Bit 2: regulator output unregulated, masked.
// [RQ8] Bit 1: brown-out, needs mask and interrupt select.
// [RQ9] Bit 0: PLL stopped oscillating, masked.
// [RQ10] Upper unused bits undefined; software leaves them.
// [RQ11] Reset-cause value reflects the causing reset sources.
// [RQ12] Pin reset sets bit 0, clears others.
// [RQ13] Other sources set their bit, accumulate.
// [RQ14] Bit 5: regulator power-good loss reset.
// [RQ15] Bit 4: software requested reset.
// [RQ16] Bit 3: watchdog reset.
// [RQ17] Bit 2: brown-out reset.
// [RQ18] Bit 1: power-on reset.
// [RQ19] Mask register at 0x054, enables reset zero.
// [RQ20] Interrupt while any masked flag set.
// [RQ21] Software writes update reset-cause bits directly.
`ifndef SCIRQ_PARAMS_SVH
`define SCIRQ_PARAMS_SVH

`define SCIRQ_OFF_BOR_CTRL 12'h030
`define SCIRQ_OFF_RAW 12'h050
`define SCIRQ_OFF_MASK 12'h054
`define SCIRQ_OFF_MISC 12'h058
`define SCIRQ_OFF_CAUSE 12'h05C

`define SCIRQ_EVT_W 7
`define SCIRQ_CAUSE_W 6
`define SCIRQ_BOR_BIT 1
`define SCIRQ_BOR_SEL_BIT 1
`define SCIRQ_PIN_BIT 0
`define SCIRQ_POR_BIT 1

`define SCIRQ_EVT_RST 7'h00
`define SCIRQ_CAUSE_PIN 6'h01
`define SCIRQ_RESP_OKAY 2'h0
`define SCIRQ_RESP_DECERR 2'h3
`define SCIRQ_WORD_ZERO 32'h00000000

`endif

// ---- rtl/scirq_pkg.sv ----
// Types shared by the system-control interrupt status block.
// Assumes AXI4-Lite with 32-bit data and a 12-bit byte address.
package scirq_pkg;

  // Fault and event flags, in status bit order 6 down to 0.
  typedef struct packed {
    logic pll_lock;
    logic current_limit;
    logic internal_osc_fault;
    logic main_osc_fault;
    logic regulator_loss;
    logic brownout;
    logic pll_fault;
  } scirq_evt_t;

  // Reset source indications, in cause bit order 5 down to 0.
  typedef struct packed {
    logic regulator_loss_reset_cause;
    logic software_reset_cause;
    logic watchdog_reset_cause;
    logic brownout_reset_cause;
    logic power_on_reset_cause;
    logic pin_reset_cause;
  } scirq_rst_src_t;

  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } scirq_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } scirq_axil_rsp_t;

  // Register selected by an address.
  typedef enum logic [4:0] {
    SCIRQ_SEL_NONE = 5'h00,
    SCIRQ_SEL_BOR = 5'h01,
    SCIRQ_SEL_RAW = 5'h02,
    SCIRQ_SEL_MASK = 5'h04,
    SCIRQ_SEL_MISC = 5'h08,
    SCIRQ_SEL_CAUSE = 5'h10
  } scirq_sel_t;

endpackage : scirq_pkg

// ---- rtl/scirq_top.sv ----
// System-control interrupt status/clear and reset-cause registers.
// Assumes event flags and reset sources are synchronous to core_clk and
// that the reset controller holds the reset sources until after rst_b rises.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "scirq_params.svh"

module scirq_top #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register bus
  input wire scirq_pkg::scirq_axil_req_t axil_req,
  output scirq_pkg::scirq_axil_rsp_t axil_rsp,
  // Fault and event flags
  input wire scirq_pkg::scirq_evt_t evt_flags,
  // Reset sources of the reset that just ended
  input wire scirq_pkg::scirq_rst_src_t rst_src,
  // Interrupt to the processor
  output logic sysctl_irq
);
  import scirq_pkg::*;

  // The bus and flag widths are fixed by the package types; refuse any other build.
  if (ADDR_W != 12) begin : g_bad_addr_w
    $error("scirq_top serves a 12-bit register address only");
  end
  if ($bits(scirq_evt_t) != `SCIRQ_EVT_W) begin : g_bad_evt_w
    $error("event flag width does not match the status register");
  end
  if ($bits(scirq_rst_src_t) != `SCIRQ_CAUSE_W) begin : g_bad_cause_w
    $error("reset source width does not match the cause register");
  end

  // A register write strobe: the write is performed, hits the register and carries lane 0.
  function automatic logic wr_hit(input logic do_wr, input scirq_sel_t at,
                                  input scirq_sel_t sel, input logic lane);
    wr_hit = do_wr && (at == sel) && lane;
  endfunction : wr_hit

  function automatic scirq_sel_t decode(input logic [11:0] addr);
    if (addr == `SCIRQ_OFF_BOR_CTRL) begin
      decode = SCIRQ_SEL_BOR;
    end else if (addr == `SCIRQ_OFF_RAW) begin
      decode = SCIRQ_SEL_RAW;
    end else if (addr == `SCIRQ_OFF_MASK) begin
      decode = SCIRQ_SEL_MASK;
    end else if (addr == `SCIRQ_OFF_MISC) begin
      decode = SCIRQ_SEL_MISC;
    end else if (addr == `SCIRQ_OFF_CAUSE) begin
      decode = SCIRQ_SEL_CAUSE;
    end else begin
      decode = SCIRQ_SEL_NONE;
    end
  endfunction : decode

  // Write and read channel state.
  logic aw_got_ff;
  logic [11:0] awaddr_ff;
  logic w_got_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arvalid_ok;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  logic aw_take;
  logic w_take;
  logic wr_do;
  scirq_sel_t wr_sel;
  logic lane0;

  assign aw_take = axil_req.awvalid && !aw_got_ff && !bvalid_ff;
  assign w_take = axil_req.wvalid && !w_got_ff && !bvalid_ff;
  assign wr_do = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_sel = decode(awaddr_ff);
  assign lane0 = wstrb_ff[0];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= 12'h000;
    end else if (aw_take) begin
      aw_got_ff <= 1'b1;
      awaddr_ff <= axil_req.awaddr;
    end else if (wr_do) begin
      aw_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      w_got_ff <= 1'b0;
      wdata_ff <= `SCIRQ_WORD_ZERO;
      wstrb_ff <= 4'h0;
    end else if (w_take) begin
      w_got_ff <= 1'b1;
      wdata_ff <= axil_req.wdata;
      wstrb_ff <= axil_req.wstrb;
    end else if (wr_do) begin
      w_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `SCIRQ_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (wr_sel == SCIRQ_SEL_NONE) ? `SCIRQ_RESP_DECERR : `SCIRQ_RESP_OKAY;
    end else if (axil_req.bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Control and status state.
  logic [`SCIRQ_EVT_W-1:0] raw_irq_status_ff;
  logic [`SCIRQ_EVT_W-1:0] irq_mask_control_ff;
  logic brownout_irq_or_reset_select_ff;
  logic [`SCIRQ_CAUSE_W-1:0] reset_cause_log_ff;
  logic cause_done_ff;
  logic [`SCIRQ_EVT_W-1:0] masked_irq_status_clear;
  logic [`SCIRQ_EVT_W-1:0] clr_bits;
  logic [`SCIRQ_EVT_W-1:0] nxt_raw;
  logic sysctl_irq_ff;

  // Each masked bit is raw AND mask; brown-out also needs the interrupt select.
  always_comb begin
    masked_irq_status_clear = raw_irq_status_ff & irq_mask_control_ff; // see [RQ1]
    if (brownout_irq_or_reset_select_ff) begin
      masked_irq_status_clear[`SCIRQ_BOR_BIT] = 1'b0; // see [RQ8]
    end
  end

  // Ones written to the masked register clear the raw flag too; zeros do nothing.
  assign clr_bits = wr_hit(wr_do, wr_sel, SCIRQ_SEL_MISC, lane0) ?
                    wdata_ff[`SCIRQ_EVT_W-1:0] : `SCIRQ_EVT_RST; // see [RQ2] [RQ20]

  // A flag that rises in the cycle it is cleared stays set: set wins.
  assign nxt_raw = (raw_irq_status_ff & ~clr_bits) | evt_flags; // see [RQ3] [RQ4] [RQ5] [RQ6] [RQ7] [RQ9]

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      raw_irq_status_ff <= `SCIRQ_EVT_RST;
    end else begin
      raw_irq_status_ff <= nxt_raw;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask_control_ff <= `SCIRQ_EVT_RST; // see [RQ19]
    end else if (wr_hit(wr_do, wr_sel, SCIRQ_SEL_MASK, lane0)) begin
      irq_mask_control_ff <= wdata_ff[`SCIRQ_EVT_W-1:0]; // see [RQ19]
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      brownout_irq_or_reset_select_ff <= 1'b0;
    end else if (wr_hit(wr_do, wr_sel, SCIRQ_SEL_BOR, lane0)) begin
      brownout_irq_or_reset_select_ff <= wdata_ff[`SCIRQ_BOR_SEL_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sysctl_irq_ff <= 1'b0;
    end else begin
      sysctl_irq_ff <= |masked_irq_status_clear; // see [RQ20]
    end
  end

  assign sysctl_irq = sysctl_irq_ff;

  // The cause log must outlive rst_b, so it has no reset; it is captured at
  // the first edge after release, when the reset sources are still held.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cause_done_ff <= 1'b0;
    end else begin
      cause_done_ff <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!cause_done_ff && rst_b) begin
      if (rst_src.pin_reset_cause) begin
        reset_cause_log_ff <= `SCIRQ_CAUSE_PIN; // see [RQ12] [RQ11]
      end else begin
        // Every source but the pin is sticky, power-on included.
        reset_cause_log_ff <= reset_cause_log_ff | rst_src; // see [RQ13] [RQ14] [RQ15] [RQ16] [RQ17] [RQ18]
      end
    end else if (wr_hit(wr_do, wr_sel, SCIRQ_SEL_CAUSE, lane0)) begin
      reset_cause_log_ff <= wdata_ff[`SCIRQ_CAUSE_W-1:0]; // see [RQ21]
    end
  end

  // Read channel; unused upper bits read as zero.
  scirq_sel_t rd_sel;
  logic [31:0] rd_word;

  assign rd_sel = decode(axil_req.araddr);
  assign arvalid_ok = axil_req.arvalid && !rvalid_ff;

  always_comb begin
    rd_word = `SCIRQ_WORD_ZERO; // see [RQ10]
    if (rd_sel == SCIRQ_SEL_BOR) begin
      rd_word[`SCIRQ_BOR_SEL_BIT] = brownout_irq_or_reset_select_ff;
    end else if (rd_sel == SCIRQ_SEL_RAW) begin
      rd_word[`SCIRQ_EVT_W-1:0] = raw_irq_status_ff;
    end else if (rd_sel == SCIRQ_SEL_MASK) begin
      rd_word[`SCIRQ_EVT_W-1:0] = irq_mask_control_ff;
    end else if (rd_sel == SCIRQ_SEL_MISC) begin
      rd_word[`SCIRQ_EVT_W-1:0] = masked_irq_status_clear;
    end else if (rd_sel == SCIRQ_SEL_CAUSE) begin
      rd_word[`SCIRQ_CAUSE_W-1:0] = reset_cause_log_ff; // see [RQ11]
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= `SCIRQ_WORD_ZERO;
      rresp_ff <= `SCIRQ_RESP_OKAY;
    end else if (arvalid_ok) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= (rd_sel == SCIRQ_SEL_NONE) ? `SCIRQ_RESP_DECERR : `SCIRQ_RESP_OKAY;
    end else if (axil_req.rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  always_comb begin
    axil_rsp.awready = !aw_got_ff && !bvalid_ff;
    axil_rsp.wready = !w_got_ff && !bvalid_ff;
    axil_rsp.bvalid = bvalid_ff;
    axil_rsp.bresp = bresp_ff;
    axil_rsp.arready = !rvalid_ff;
    axil_rsp.rvalid = rvalid_ff;
    axil_rsp.rdata = rdata_ff;
    axil_rsp.rresp = rresp_ff;
  end

endmodule : scirq_top

// ---- verif/scirq_chk.sv ----
// Bus and interrupt checks for the interrupt status and reset-cause block.
// Assumes it is bound to scirq_top and sees only that module's ports.
`timescale 1ns/100ps
module scirq_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register bus and interrupt
  input wire scirq_pkg::scirq_axil_req_t axil_req,
  input wire scirq_pkg::scirq_axil_rsp_t axil_rsp,
  input wire logic sysctl_irq
);
  import scirq_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_rd_latency: assert property (
    axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
    else $error("read answer not one cycle after address");
  a_wr_latency: assert property (
    axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready
    |-> ##2 axil_rsp.bvalid)
    else $error("write answer not two cycles after address");
  a_rvalid_drop: assert property (
    axil_rsp.rvalid && axil_req.rready |=> !axil_rsp.rvalid)
    else $error("read answer stayed after being taken");
  a_bvalid_drop: assert property (
    axil_rsp.bvalid && axil_req.bready |=> !axil_rsp.bvalid)
    else $error("write answer stayed after being taken");
  a_upper_zero: assert property (
    axil_rsp.rvalid |-> axil_rsp.rdata[31:7] == 25'h0)
    else $error("unused read bits not zero");
  a_rd_unmapped: assert property (
    axil_req.arvalid && axil_rsp.arready && axil_req.araddr == 12'h100
    |=> axil_rsp.rresp == 2'h3 && axil_rsp.rdata == 32'h0)
    else $error("unmapped read not refused");
  a_ar_blocked: assert property (
    axil_rsp.rvalid |-> !axil_rsp.arready)
    else $error("read address taken while answer pending");
  a_irq_reset: assert property (
    $rose(rst_b) |-> !sysctl_irq)
    else $error("interrupt high straight after reset");
endmodule : scirq_chk

// ---- verif/scirq_rst_model.sv ----
// Reset controller model: drives rst_b and the reset source lines.
// Assumes the bench calls pulse only while the register bus is idle.
`timescale 1ns/100ps
module scirq_rst_model (
  // Clock
  input wire logic core_clk,
  // Reset outputs
  output logic rst_b,
  output scirq_pkg::scirq_rst_src_t rst_src
);
  import scirq_pkg::*;
  initial begin
    rst_b = 1'b0;
    rst_src = 6'h01;
  end
  // Sources stay up past release, since the log is captured at the first edge.
  task automatic pulse(input logic [5:0] src);
    @(posedge core_clk);
    rst_b <= 1'b0;
    rst_src <= src;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst_src <= 6'h00;
  endtask : pulse
endmodule : scirq_rst_model

// ---- verif/sysctl_irq_status_reset_cause_tb_top.sv ----
// Register-level bench of the interrupt status and reset-cause block.
// Assumes the package, scirq_top, the checker and the reset model compile first.
`timescale 1ns/100ps
module sysctl_irq_status_reset_cause_tb_top;
  import scirq_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b;
  scirq_rst_src_t rst_src;
  scirq_axil_req_t req = '0;
  scirq_axil_rsp_t rsp;
  scirq_evt_t evt = '0;
  logic irq;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] rdat;
  logic [31:0] acc;
  logic [1:0] resp;
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  scirq_rst_model scirq_rst_model_inst (.core_clk(core_clk), .rst_b(rst_b), .rst_src(rst_src));
  scirq_top #(.ADDR_W(12)) scirq_top_inst (.core_clk(core_clk), .rst_b(rst_b), .axil_req(req),
    .axil_rsp(rsp), .evt_flags(evt), .rst_src(rst_src), .sysctl_irq(irq));
  task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // Readies are sampled mid-cycle, so what is seen there is what the next rise takes.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge core_clk);
    req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: s, bready: 1'b1,
      default: '0};
    do begin
      @(negedge core_clk);
      ta = ta | rsp.awready;
      tw = tw | rsp.wready;
      @(posedge core_clk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
    end while (!(ta && tw));
    do begin
      @(negedge core_clk);
      ta = rsp.bvalid;
      resp = rsp.bresp;
      @(posedge core_clk);
    end while (!ta);
    req.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    logic t;
    @(posedge core_clk);
    req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    do begin
      @(negedge core_clk);
      t = rsp.arready;
      @(posedge core_clk);
    end while (!t);
    req.arvalid <= 1'b0;
    do begin
      @(negedge core_clk);
      t = rsp.rvalid;
      rdat = rsp.rdata;
      resp = rsp.rresp;
      @(posedge core_clk);
    end while (!t);
    req.rready <= 1'b0;
  endtask : rd
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    rd(a);
    chk(rdat, exp);
  endtask : rdc
  task automatic ev(input logic [6:0] v);
    @(posedge core_clk);
    evt <= v;
    @(posedge core_clk);
    evt <= '0;
  endtask : ev
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    scirq_rst_model_inst.pulse(6'h01);
    rdc(12'h05C, 32'h01);
    rdc(12'h054, 32'h00);
    rdc(12'h058, 32'h00);
    wr(12'h054, 32'h7F);
    rdc(12'h054, 32'h7F);
    // A write without the low byte lane must leave the masks alone.
    wr(12'h054, 32'h00, 4'hE);
    rdc(12'h054, 32'h7F);
    for (int i = 0; i < 7; i++) begin
      ev(7'h01 << i);
      rdc(12'h058, 32'h1 << i);
      chk({31'h0, irq}, 32'h1);
      wr(12'h058, 32'h0);
      rdc(12'h058, 32'h1 << i);
      wr(12'h058, 32'h1 << i);
      rdc(12'h050, 32'h0);
      rdc(12'h058, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    wr(12'h030, 32'h2);
    ev(7'h02);
    rdc(12'h058, 32'h0);
    rdc(12'h050, 32'h2);
    wr(12'h030, 32'h0);
    rdc(12'h058, 32'h2);
    wr(12'h054, 32'h0);
    ev(7'h7F);
    rdc(12'h058, 32'h0);
    rdc(12'h050, 32'h7F);
    chk({31'h0, irq}, 32'h0);
    rd(12'h100);
    chk({30'h0, resp}, 32'h3);
    wr(12'h100, 32'h1);
    chk({30'h0, resp}, 32'h3);
    wr(12'h05C, 32'h0);
    rdc(12'h05C, 32'h0);
    acc = 32'h0;
    for (int i = 2; i < 6; i++) begin
      scirq_rst_model_inst.pulse(6'h01 << i);
      acc = acc | (32'h1 << i);
      rdc(12'h05C, acc);
    end
    // Power-on is not the pin, so the causes already logged stay.
    scirq_rst_model_inst.pulse(6'h02);
    rdc(12'h05C, 32'h3E);
    wr(12'h05C, 32'h3C);
    scirq_rst_model_inst.pulse(6'h01);
    rdc(12'h05C, 32'h01);
    results();
  end
endmodule : sysctl_irq_status_reset_cause_tb_top
bind scirq_top scirq_chk scirq_chk_inst (.core_clk(core_clk), .rst_b(rst_b),
  .axil_req(axil_req), .axil_rsp(axil_rsp), .sysctl_irq(sysctl_irq));
